// ===== hw/prm_pkg.sv
package prm_pkg;
  // register indexes; byte address is four times the index
  localparam logic [6:0] A_RAM_LAST    = 7'h4F;
  localparam logic [6:0] A_PORT_LOW    = 7'h50;
  localparam logic [6:0] A_PORT_OE     = 7'h51;
  localparam logic [6:0] A_EDGE_DEB    = 7'h52;
  localparam logic [6:0] A_IRQ_WAKE    = 7'h53;
  localparam logic [6:0] A_PD_OFF      = 7'h54;
  localparam logic [6:0] A_OPEN_DRAIN  = 7'h55;
  localparam logic [6:0] A_FREQ_RST    = 7'h56;
  localparam logic [6:0] A_SER_CTRL1   = 7'h57;
  localparam logic [6:0] A_SER_CTRL2   = 7'h58;
  localparam logic [6:0] A_SER_DATA_L  = 7'h59;
  localparam logic [6:0] A_SER_DATA_H  = 7'h5A;
  localparam logic [6:0] A_CNT_CTRL1   = 7'h5B;
  localparam logic [6:0] A_CNT_CTRL2   = 7'h5C;
  localparam logic [6:0] A_CNT_LOW     = 7'h5D;
  localparam logic [6:0] A_CNT_MID     = 7'h5E;
  localparam logic [6:0] A_CNT_HIGH    = 7'h5F;
  localparam logic [6:0] A_PORT_HIGH   = 7'h60;
  localparam logic [6:0] A_ROUTE1      = 7'h61;
  localparam logic [6:0] A_ROUTE2      = 7'h62;
  localparam logic [6:0] A_MASK1       = 7'h65;
  localparam logic [6:0] A_MASK2       = 7'h66;
  localparam logic [6:0] A_FLAGS1      = 7'h67;
  localparam logic [6:0] A_FLAGS2      = 7'h68;
  localparam logic [6:0] A_SYS1        = 7'h69;
  localparam logic [6:0] A_SYS2        = 7'h6A;
  localparam logic [6:0] A_SLEEP_CR    = 7'h6B;
  localparam int         RAM_DEPTH     = 80;
  // field positions
  localparam int         CNT_LOAD_BIT  = 0;
  localparam int         SLEEP_CMD_BIT = 2;
  localparam int         SLEEP_EN_BIT  = 2;
  localparam int         WD_CLEAR_BIT  = 3;
  localparam int         GIE_BIT       = 3;
  // reset values
  localparam logic [3:0] NIB_RST       = 4'h0;
  localparam logic [1:0] FREQ_SEL_RST  = 2'h0;
  localparam logic       POR_FLAG_RST  = 1'b1;
  localparam logic [3:0] ROUTE2_RST    = 4'h3;
  typedef enum {BUS_IDLE, BUS_ACCESS, BUS_ANSWER} prm_bus_t;
endpackage

// ===== hw/prm_nibble_ram.sv
`timescale 1ns/1ps
module prm_nibble_ram #(
  parameter int DEPTH = 80,
  parameter int AW    = 7
) (
  input  wire logic          clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] addr,
  input  wire logic [3:0]    wr_data,
  output logic      [3:0]    rd_data
);
  logic [3:0] mem [DEPTH];

  if (DEPTH > (1 << AW)) begin : g_bad_depth
    $error("ram depth exceeds address range");
  end

  // no reset: contents are undefined until written
  always_ff @(posedge clk) begin
    if (wr_en && (32'(addr) < DEPTH)) begin
      mem[addr] <= wr_data;
    end
    rd_data <= (32'(addr) < DEPTH) ? mem[addr] : 4'h0;
  end
endmodule // prm_nibble_ram

// ===== hw/prm_irq_flags.sv
`timescale 1ns/1ps
module prm_irq_flags #(
  parameter int N = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] req,
  input  wire logic [N-1:0] mask,
  input  wire logic         clr_wr,
  input  wire logic [N-1:0] clr_data,
  input  wire logic         clr_rd,
  output logic      [N-1:0] flags_reg
);
  logic [N-1:0] req_d_reg;
  logic [N-1:0] set;
  logic [N-1:0] clr;

  if (N < 1) begin : g_bad_n
    $error("flag count must be positive");
  end

  // rising edge only, gated by mask, not by the global enable
  assign set = req & ~req_d_reg & mask;
  assign clr = (clr_wr ? clr_data : '0) | {N{clr_rd}};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_d_reg <= '0;
      flags_reg <= '0;
    end else begin
      req_d_reg <= req;
      flags_reg <= (flags_reg & ~clr) | set; // set wins over a clear
    end
  end
endmodule // prm_irq_flags

// ===== hw/prm_periph_map.sv
// Behaviour
// RULE1 - registers take reset values on power-up and system reset, except power-on-only fields
// RULE2 - indexes 00 to 4F are eighty undefined read/write nibbles
// RULE3 - port data reads give live pin levels, writes load output latches
// RULE4 - per-pin drive enables at 51 and 60 bit 2, cleared by reset
// RULE5 - bit set at 54 disconnects the low pin pull-down
// RULE6 - bit set at 55 makes the low pin open-drain
// RULE7 - 52 holds edge polarity and debounce bypass per input pair
// RULE8 - 53 holds interrupt pin choice and wake-on-change per input pair
// RULE9 - 61 and 62 route peripheral signals onto output pins
// RULE10 - 56 holds frequency select, reset-input enable and its polarity
// RULE11 - serial control at 57, 58 and eight data bits at 59/5A
// RULE12 - counter control at 5B and 5C, load strobe reads zero
// RULE13 - mask bit 1 lets a request be stored, 0 blocks it
// RULE14 - flag registers 67 and 68 report the eight request sources
// RULE15 - writing 1 clears a flag, writing 0 leaves it
// RULE16 - 69 holds test disable, irq select, global enable; sleep is write-only
// RULE17 - 6A reads watchdog, sleep enable, power-on flag; bit 3 clears watchdog
// RULE18 - 6B fields are set only by power-on reset
// RULE19 - reading a flag register clears all its flags
// RULE20 - flags set on request rising edge with mask 1, ignoring global enable
// RULE21 - entering halt sets the global interrupt enable
// RULE22 - 5D..5F read running count, write load value; 5F bits 3:2 select
// RULE23 - 63 and 64 read zero and ignore writes
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
module prm_periph_map (
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic        POR_N,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [8:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic [5:0]  PA_I,
  output logic      [5:0]  PA_O,
  output logic      [5:0]  PA_OE,
  output logic      [5:0]  PULLDOWN_OFF,
  input  wire logic        PWM_I,
  input  wire logic        SER_CLK_I,
  input  wire logic        SER_STB_I,
  input  wire logic        SER_OUT_I,
  input  wire logic        FREQ_I,
  input  wire logic        SER_STATUS_I,
  input  wire logic        SER_RX_VALID_I,
  input  wire logic [7:0]  SER_RX_DATA_I,
  input  wire logic [9:0]  CNT_VALUE_I,
  input  wire logic [1:0]  WD_VALUE_I,
  input  wire logic        HALT_I,
  input  wire logic [7:0]  IRQ_SRC_I,
  output logic      [3:0]  EDGE_DEB_CTRL,
  output logic      [3:0]  IRQ_WAKE_CTRL,
  output logic      [3:0]  FREQ_RST_CTRL,
  output logic      [3:0]  SER_CTRL1,
  output logic      [3:0]  SER_CTRL2,
  output logic      [7:0]  SER_TX_DATA,
  output logic      [3:0]  CNT_CTRL1,
  output logic      [2:0]  CNT_CTRL2,
  output logic             CNT_LOAD,
  output logic      [9:0]  CNT_LOAD_VALUE,
  output logic      [1:0]  CNT_BIT_SELECT,
  output logic             TEST_MODE_DISABLE,
  output logic             IRQ_SELECT,
  output logic             GLOBAL_IRQ_ENABLE,
  output logic             SLEEP_CMD,
  output logic             SLEEP_ALLOW,
  output logic             WATCHDOG_CLEAR,
  output logic             POWER_ON_FLAG,
  output logic      [3:0]  SLEEP_CR,
  output logic             IRQ_TO_CPU
);
  import prm_pkg::*;

  logic             rst_all_n;
  prm_bus_t         bus_reg;
  logic [6:0]       idx;
  logic [3:0]       wd;
  logic             wr;
  logic             rd;
  logic [3:0]       ram_rd;
  logic [3:0]       rd_nib;
  logic [5:0]       pa_s1_reg;
  logic [5:0]       pa_s2_reg;
  logic [3:0]       latch_low_reg;
  logic             latch5_reg;
  logic [3:0]       oe_low_reg;
  logic             oe5_reg;
  logic [3:0]       od_low_reg;
  logic             od5_reg;
  logic [3:0]       route1_reg;
  logic [3:0]       route2_reg;
  logic [3:0]       pd_off_reg;
  logic [3:0]       mask1_reg;
  logic [3:0]       mask2_reg;
  logic [3:0]       flags1;
  logic [3:0]       flags2;
  logic             halt_d_reg;
  logic [5:0]       out_next;
  logic [5:0]       oe_next;
  logic [5:0]       od_vec;

  // power-on reset also counts as a system reset
  assign rst_all_n = RST_N & POR_N; // RULE1
  assign idx       = WB_ADR_I[8:2];
  assign wd        = WB_DAT_I[3:0];
  assign wr        = (bus_reg == BUS_ACCESS) && WB_WE_I && WB_SEL_I[0];
  assign rd        = (bus_reg == BUS_ACCESS) && !WB_WE_I;

  // two-flop synchroniser for the pins
  always_ff @(posedge CLOCK or negedge rst_all_n) begin
    if (!rst_all_n) begin
      pa_s1_reg <= 6'h00;
      pa_s2_reg <= 6'h00;
    end else begin
      pa_s1_reg <= PA_I;
      pa_s2_reg <= pa_s1_reg;
    end
  end

  // bus sequencer: request, access cycle, one-cycle ack
  always_ff @(posedge CLOCK or negedge rst_all_n) begin
    if (!rst_all_n) begin
      bus_reg <= BUS_IDLE;
    end else begin
      case (bus_reg)
        BUS_IDLE:   if (WB_CYC_I && WB_STB_I) bus_reg <= BUS_ACCESS;
        BUS_ACCESS: bus_reg <= BUS_ANSWER;
        BUS_ANSWER: bus_reg <= BUS_IDLE;
        default:    bus_reg <= BUS_IDLE;
      endcase
    end
  end

  // ram read data comes out registered, ready for the access cycle
  prm_nibble_ram #(.DEPTH(RAM_DEPTH), .AW(7)) u_ram (
    .clk     (CLOCK),
    .wr_en   (wr && idx <= A_RAM_LAST), // RULE2
    .addr    (idx),
    .wr_data (wd),
    .rd_data (ram_rd)
  );

  // port latches and drive enables; both clear on any reset
  always_ff @(posedge CLOCK or negedge rst_all_n) begin
    if (!rst_all_n) begin
      latch_low_reg <= NIB_RST;
      latch5_reg    <= 1'b0;
      oe_low_reg    <= NIB_RST;
      oe5_reg       <= 1'b0;
    end else if (wr) begin
      if (idx == A_PORT_LOW) latch_low_reg <= wd; // RULE3
      if (idx == A_PORT_OE) oe_low_reg <= wd; // RULE4
      if (idx == A_PORT_HIGH) begin
        latch5_reg <= wd[1]; // RULE3
        oe5_reg    <= wd[2]; // RULE4
      end
    end
  end

  // option fields kept across system resets, set only at power-on
  always_ff @(posedge CLOCK or negedge POR_N) begin
    if (!POR_N) begin
      EDGE_DEB_CTRL     <= NIB_RST;
      IRQ_WAKE_CTRL     <= NIB_RST;
      pd_off_reg        <= NIB_RST;
      od_low_reg        <= NIB_RST;
      od5_reg           <= 1'b0;
      FREQ_RST_CTRL     <= NIB_RST;
      route1_reg        <= NIB_RST;
      route2_reg        <= ROUTE2_RST;
      TEST_MODE_DISABLE <= 1'b0;
      SLEEP_ALLOW       <= 1'b0;
      SLEEP_CR          <= NIB_RST;
    end else if (wr) begin
      case (idx)
        A_EDGE_DEB:   EDGE_DEB_CTRL <= wd; // RULE7
        A_IRQ_WAKE:   IRQ_WAKE_CTRL <= wd; // RULE8
        A_PD_OFF:     pd_off_reg <= wd; // RULE5
        A_OPEN_DRAIN: od_low_reg <= wd; // RULE6
        A_FREQ_RST:   FREQ_RST_CTRL <= wd; // RULE10
        A_PORT_HIGH:  od5_reg <= wd[3];
        A_ROUTE1:     route1_reg <= wd; // RULE9
        A_ROUTE2:     route2_reg <= wd; // RULE9
        A_SYS1:       TEST_MODE_DISABLE <= wd[0]; // RULE16
        A_SYS2:       SLEEP_ALLOW <= wd[SLEEP_EN_BIT]; // RULE17
        A_SLEEP_CR:   SLEEP_CR <= wd; // RULE18
        default:      ;
      endcase
    end
  end

  // serial registers; a finished transfer overwrites the data nibbles
  always_ff @(posedge CLOCK or negedge rst_all_n) begin
    if (!rst_all_n) begin
      SER_CTRL1   <= NIB_RST;
      SER_CTRL2   <= NIB_RST;
      SER_TX_DATA <= 8'h00;
    end else begin
      if (wr && idx == A_SER_CTRL1) SER_CTRL1 <= wd; // RULE11
      if (wr && idx == A_SER_CTRL2) SER_CTRL2 <= wd; // RULE11
      if (SER_RX_VALID_I) begin
        SER_TX_DATA <= SER_RX_DATA_I;
      end else if (wr && idx == A_SER_DATA_L) begin
        SER_TX_DATA[3:0] <= wd; // RULE11
      end else if (wr && idx == A_SER_DATA_H) begin
        SER_TX_DATA[7:4] <= wd; // RULE11
      end
    end
  end

  // counter control; load is a one-cycle strobe and is never stored
  always_ff @(posedge CLOCK or negedge rst_all_n) begin
    if (!rst_all_n) begin
      CNT_CTRL1      <= NIB_RST;
      CNT_CTRL2      <= 3'h0;
      CNT_LOAD       <= 1'b0;
      CNT_LOAD_VALUE <= 10'h000;
      CNT_BIT_SELECT <= 2'h0;
    end else begin
      CNT_LOAD <= wr && idx == A_CNT_CTRL2 && wd[CNT_LOAD_BIT]; // RULE12
      if (wr) begin
        case (idx)
          A_CNT_CTRL1: CNT_CTRL1 <= wd; // RULE12
          A_CNT_CTRL2: CNT_CTRL2 <= wd[3:1]; // RULE12
          A_CNT_LOW:   CNT_LOAD_VALUE[3:0] <= wd; // RULE22
          A_CNT_MID:   CNT_LOAD_VALUE[7:4] <= wd; // RULE22
          A_CNT_HIGH: begin
            CNT_LOAD_VALUE[9:8] <= wd[1:0]; // RULE22
            CNT_BIT_SELECT      <= wd[3:2]; // RULE22
          end
          default: ;
        endcase
      end
    end
  end

  // interrupt masks
  always_ff @(posedge CLOCK or negedge rst_all_n) begin
    if (!rst_all_n) begin
      mask1_reg <= NIB_RST;
      mask2_reg <= NIB_RST;
    end else if (wr) begin
      if (idx == A_MASK1) mask1_reg <= wd; // RULE13
      if (idx == A_MASK2) mask2_reg <= wd; // RULE13
    end
  end

  // flag banks: pair sources 0/5, 3/4, compare, zero; serial, level, 64/8, 1 Hz
  prm_irq_flags #(.N(4)) u_flags1 (
    .clk       (CLOCK),
    .rst_n     (rst_all_n),
    .req       (IRQ_SRC_I[3:0]), // RULE14
    .mask      (mask1_reg), // RULE13
    .clr_wr    (wr && idx == A_FLAGS1), // RULE15
    .clr_data  (wd),
    .clr_rd    (rd && idx == A_FLAGS1), // RULE19
    .flags_reg (flags1) // RULE20
  );

  prm_irq_flags #(.N(4)) u_flags2 (
    .clk       (CLOCK),
    .rst_n     (rst_all_n),
    .req       (IRQ_SRC_I[7:4]), // RULE14
    .mask      (mask2_reg), // RULE13
    .clr_wr    (wr && idx == A_FLAGS2), // RULE15
    .clr_data  (wd),
    .clr_rd    (rd && idx == A_FLAGS2), // RULE19
    .flags_reg (flags2) // RULE20
  );

  // system control; halt entry forces the global enable on and wins over a write
  always_ff @(posedge CLOCK or negedge rst_all_n) begin
    if (!rst_all_n) begin
      IRQ_SELECT        <= 1'b0;
      GLOBAL_IRQ_ENABLE <= 1'b0;
      SLEEP_CMD         <= 1'b0;
      WATCHDOG_CLEAR    <= 1'b0;
      halt_d_reg        <= 1'b0;
      IRQ_TO_CPU        <= 1'b0;
    end else begin
      halt_d_reg     <= HALT_I;
      SLEEP_CMD      <= wr && idx == A_SYS1 && wd[SLEEP_CMD_BIT]; // RULE16
      WATCHDOG_CLEAR <= wr && idx == A_SYS2 && wd[WD_CLEAR_BIT]; // RULE17
      if (wr && idx == A_SYS1) IRQ_SELECT <= wd[1]; // RULE16
      if (HALT_I && !halt_d_reg) begin
        GLOBAL_IRQ_ENABLE <= 1'b1; // RULE21
      end else if (wr && idx == A_SYS1) begin
        GLOBAL_IRQ_ENABLE <= wd[GIE_BIT]; // RULE16
      end
      IRQ_TO_CPU <= GLOBAL_IRQ_ENABLE && (|{flags1, flags2});
    end
  end

  // power-on status: set at power-up only, cleared by reading it
  always_ff @(posedge CLOCK or negedge POR_N) begin
    if (!POR_N) begin
      POWER_ON_FLAG <= POR_FLAG_RST; // RULE18
    end else if (rd && idx == A_SYS2) begin
      POWER_ON_FLAG <= 1'b0;
    end
  end

  // pin routing and open-drain drive, registered toward the pads
  always_comb begin
    out_next[0] = route1_reg[0] ? PWM_I : latch_low_reg[0]; // RULE9
    out_next[1] = route1_reg[1] ? PWM_I : (route1_reg[2] ? SER_CLK_I : latch_low_reg[1]);
    out_next[2] = route2_reg[0] ? FREQ_I : latch_low_reg[2];
    out_next[3] = route1_reg[3] ? SER_STB_I : latch_low_reg[3];
    out_next[4] = 1'b0;
    out_next[5] = route2_reg[2] ? FREQ_I : (route2_reg[1] ? SER_OUT_I : latch5_reg);
    od_vec      = {od5_reg, 1'b0, od_low_reg};
    // open-drain pins only pull low, never drive high
    oe_next     = {oe5_reg, 1'b0, oe_low_reg} & ~(od_vec & out_next); // RULE6
  end

  always_ff @(posedge CLOCK or negedge rst_all_n) begin
    if (!rst_all_n) begin
      PA_O         <= 6'h00;
      PA_OE        <= 6'h00;
      PULLDOWN_OFF <= 6'h00;
    end else begin
      PA_O         <= out_next & ~od_vec; // RULE4
      PA_OE        <= oe_next; // RULE4
      PULLDOWN_OFF <= {route2_reg[3], SLEEP_CR[3], pd_off_reg}; // RULE5
    end
  end

  // read mux; unmapped and gap indexes answer zero
  always_comb begin
    rd_nib = 4'h0; // RULE23
    if (idx <= A_RAM_LAST) begin
      rd_nib = ram_rd; // RULE2
    end else begin
      case (idx)
        A_PORT_LOW:   rd_nib = pa_s2_reg[3:0]; // RULE3
        A_PORT_OE:    rd_nib = oe_low_reg;
        A_EDGE_DEB:   rd_nib = EDGE_DEB_CTRL;
        A_IRQ_WAKE:   rd_nib = IRQ_WAKE_CTRL;
        A_PD_OFF:     rd_nib = pd_off_reg;
        A_OPEN_DRAIN: rd_nib = od_low_reg;
        A_FREQ_RST:   rd_nib = FREQ_RST_CTRL;
        A_SER_CTRL1:  rd_nib = SER_CTRL1;
        A_SER_CTRL2:  rd_nib = {SER_CTRL2[3], SER_STATUS_I, SER_CTRL2[1:0]}; // RULE11
        A_SER_DATA_L: rd_nib = SER_TX_DATA[3:0];
        A_SER_DATA_H: rd_nib = SER_TX_DATA[7:4];
        A_CNT_CTRL1:  rd_nib = CNT_CTRL1;
        A_CNT_CTRL2:  rd_nib = {CNT_CTRL2, 1'b0}; // RULE12
        A_CNT_LOW:    rd_nib = CNT_VALUE_I[3:0]; // RULE22
        A_CNT_MID:    rd_nib = CNT_VALUE_I[7:4];
        A_CNT_HIGH:   rd_nib = {CNT_BIT_SELECT, CNT_VALUE_I[9:8]};
        A_PORT_HIGH:  rd_nib = {od5_reg, oe5_reg, pa_s2_reg[5:4]}; // RULE3
        A_ROUTE1:     rd_nib = route1_reg;
        A_ROUTE2:     rd_nib = route2_reg;
        A_MASK1:      rd_nib = mask1_reg;
        A_MASK2:      rd_nib = mask2_reg;
        A_FLAGS1:     rd_nib = flags1; // RULE14
        A_FLAGS2:     rd_nib = flags2; // RULE14
        A_SYS1:       rd_nib = {GLOBAL_IRQ_ENABLE, 1'b0, IRQ_SELECT, TEST_MODE_DISABLE}; // RULE16
        A_SYS2:       rd_nib = {POWER_ON_FLAG, SLEEP_ALLOW, WD_VALUE_I}; // RULE17
        A_SLEEP_CR:   rd_nib = SLEEP_CR;
        default:      rd_nib = 4'h0;
      endcase
    end
  end

  // answer register; data sampled in the access cycle, before any clear-on-read
  always_ff @(posedge CLOCK or negedge rst_all_n) begin
    if (!rst_all_n) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= bus_reg == BUS_ACCESS;
      if (rd) WB_DAT_O <= {28'h000_0000, rd_nib};
    end
  end
endmodule // prm_periph_map

// ===== test/prm_periph_map_properties.sv
`timescale 1ns/1ps
module prm_periph_map_checker (
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire logic        POR_N,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [8:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        HALT_I,
  input wire logic        CNT_LOAD,
  input wire logic        SLEEP_CMD,
  input wire logic        WATCHDOG_CLEAR,
  input wire logic        GLOBAL_IRQ_ENABLE,
  input wire logic        IRQ_TO_CPU
);
  import prm_pkg::*;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N || !POR_N);
  // decoded write and read answers
  logic [6:0] idx;
  logic       req;
  logic       wr_ack;
  logic       rd_ack;
  assign idx    = WB_ADR_I[8:2];
  assign req    = WB_CYC_I && WB_STB_I;
  assign wr_ack = WB_ACK_O && WB_WE_I && WB_SEL_I[0];
  assign rd_ack = WB_ACK_O && !WB_WE_I;

  a_ack_timing: assert property ($rose(req) |-> !WB_ACK_O ##2 WB_ACK_O) else $error("ack not two cycles after request");
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
  a_ack_cause: assert property (WB_ACK_O |-> req && $past(req, 2)) else $error("ack without request");
  a_read_upper_zero: assert property (rd_ack |-> WB_DAT_O[31:4] == 28'h0) else $error("read data upper bits set");
  a_hole_reads_zero: assert property (rd_ack && (idx == 7'h63 || idx == 7'h64) |-> WB_DAT_O == 32'h0)
    else $error("unassigned address read nonzero");
  a_load_reads_zero: assert property (rd_ack && idx == A_CNT_CTRL2 |-> !WB_DAT_O[0]) else $error("load bit read as one");
  a_load_strobe: assert property (wr_ack && idx == A_CNT_CTRL2 && WB_DAT_I[0] |-> ##[0:1] CNT_LOAD)
    else $error("load strobe missing");
  a_load_pulse: assert property (CNT_LOAD |=> !CNT_LOAD) else $error("load strobe too long");
  a_sleep_strobe: assert property (wr_ack && idx == A_SYS1 && WB_DAT_I[2] |-> ##[0:1] SLEEP_CMD)
    else $error("sleep command missing");
  a_wd_clear: assert property (wr_ack && idx == A_SYS2 && WB_DAT_I[3] |-> ##[0:1] WATCHDOG_CLEAR)
    else $error("watchdog clear missing");
  a_halt_sets_gie: assert property ($rose(HALT_I) |-> ##[1:3] GLOBAL_IRQ_ENABLE)
    else $error("halt did not set global enable");
  a_gie_gates_irq: assert property (!GLOBAL_IRQ_ENABLE |=> !IRQ_TO_CPU) else $error("irq without global enable");

  c_load: cover property (wr_ack && idx == A_CNT_CTRL2 && WB_DAT_I[0]);
  c_halt: cover property ($rose(HALT_I));
  c_irq: cover property (IRQ_TO_CPU);
endmodule // prm_periph_map_checker

bind prm_periph_map prm_periph_map_checker u_chk (.CLOCK(CLOCK), .RST_N(RST_N), .POR_N(POR_N),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
  .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .HALT_I(HALT_I), .CNT_LOAD(CNT_LOAD),
  .SLEEP_CMD(SLEEP_CMD), .WATCHDOG_CLEAR(WATCHDOG_CLEAR), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
  .IRQ_TO_CPU(IRQ_TO_CPU));

// ===== test/prm_pin_model.sv
`timescale 1ns/1ps
module prm_pin_model (
  input  wire logic       clk,
  input  wire logic [5:0] pa_o,
  input  wire logic [5:0] pa_oe,
  input  wire logic [5:0] pd_off,
  output logic      [5:0] pa_i
);
  logic [5:0] wander_reg = 6'h15;
  // a pin with no driver and no pull is not trusted to hold a level
  always_ff @(posedge clk) begin
    wander_reg <= ~wander_reg;
  end
  // pad level: driver first, then pull-down, else wandering
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pa_i[i] = pa_oe[i] ? pa_o[i] : (pd_off[i] ? wander_reg[i] : 1'h0);
    end
  end
endmodule // prm_pin_model

// ===== test/prm_periph_map_tb.sv
`timescale 1ns/1ps
module prm_periph_map_tb;
  import prm_pkg::*;
  logic        clk = 1'h0, rst_n = 1'h0, por_n = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [8:0]  adr = 9'h000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dati = 32'h0, dato;
  logic        ack, pwm = 1'h0, halt = 1'h0, ser_st = 1'h0, rx_v = 1'h0, sleep_allow, irq_cpu;
  logic [7:0]  rx_d = 8'h00, src = 8'h00, ser_tx;
  logic [9:0]  cnt = 10'h000, cnt_lv;
  logic [1:0]  wd = 2'h1, cnt_bs;
  logic [2:0]  cnt_c2;
  logic [5:0]  pa_i, pa_o, pa_oe, pd_off;
  int          failures = 0, tests_run = 0, cycles = 0;
  logic [6:0]  zero_ix [12] = '{A_PORT_OE, A_SER_CTRL1, A_SER_CTRL2, A_SER_DATA_L, A_SER_DATA_H, A_CNT_CTRL1,
                                A_CNT_CTRL2, A_MASK1, A_MASK2, A_FLAGS1, A_FLAGS2, A_SYS1};
  logic [6:0]  cfg_ix [6] = '{A_EDGE_DEB, A_IRQ_WAKE, A_FREQ_RST, A_ROUTE1, A_CNT_CTRL1, A_MASK2};

  always #2.5 clk = ~clk;

  prm_periph_map dut (.CLOCK(clk), .RST_N(rst_n), .POR_N(por_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dati), .WB_DAT_O(dato), .WB_ACK_O(ack), .PA_I(pa_i), .PA_O(pa_o),
    .PA_OE(pa_oe), .PULLDOWN_OFF(pd_off), .PWM_I(pwm), .SER_CLK_I(1'h0), .SER_STB_I(1'h0), .SER_OUT_I(1'h0),
    .FREQ_I(1'h0), .SER_STATUS_I(ser_st), .SER_RX_VALID_I(rx_v), .SER_RX_DATA_I(rx_d), .CNT_VALUE_I(cnt),
    .WD_VALUE_I(wd), .HALT_I(halt), .IRQ_SRC_I(src), .EDGE_DEB_CTRL(), .IRQ_WAKE_CTRL(), .FREQ_RST_CTRL(),
    .SER_CTRL1(), .SER_CTRL2(), .SER_TX_DATA(ser_tx), .CNT_CTRL1(), .CNT_CTRL2(cnt_c2), .CNT_LOAD(),
    .CNT_LOAD_VALUE(cnt_lv), .CNT_BIT_SELECT(cnt_bs), .TEST_MODE_DISABLE(), .IRQ_SELECT(),
    .GLOBAL_IRQ_ENABLE(), .SLEEP_CMD(), .SLEEP_ALLOW(sleep_allow), .WATCHDOG_CLEAR(), .POWER_ON_FLAG(),
    .SLEEP_CR(), .IRQ_TO_CPU(irq_cpu));

  prm_pin_model u_pins (.clk(clk), .pa_o(pa_o), .pa_oe(pa_oe), .pd_off(pd_off), .pa_i(pa_i));

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // hang guard, over seven thousand cycles of margin over the sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 8000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one classic cycle; held until ack is sampled high
  task automatic acc(input logic w, input logic [6:0] ix, input logic [3:0] d, output logic [3:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= {ix, 2'h0};
    sel <= 4'hF;
    dati <= {28'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 40);
    q = dato[3:0];
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    if (n >= 40) failures++;
  endtask

  task automatic wr(input logic [6:0] ix, input logic [3:0] d);
    logic [3:0] q;
    acc(1'h1, ix, d, q);
  endtask

  task automatic rd(input logic [6:0] ix, input logic [3:0] e);
    logic [3:0] q;
    acc(1'h0, ix, 4'h0, q);
    check($sformatf("register %h", ix), {28'h0, q}, {28'h0, e});
  endtask

  // request held a few cycles so the edge is seen once
  task automatic pulse(input logic [7:0] s);
    @(posedge clk);
    src <= s;
    repeat (2) @(posedge clk);
    src <= 8'h00;
    repeat (2) @(posedge clk);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    por_n <= 1'h1;
    foreach (zero_ix[i]) rd(zero_ix[i], 4'h0);
    rd(A_ROUTE2, 4'h3);
    rd(A_SYS2, 4'h9);
    rd(A_SYS2, 4'h1);
    wr(7'h00, 4'h3);
    wr(A_RAM_LAST, 4'hC);
    rd(7'h00, 4'h3);
    rd(A_RAM_LAST, 4'hC);
    wr(7'h63, 4'hF);
    rd(7'h63, 4'h0);
    rd(7'h64, 4'h0);
    foreach (cfg_ix[i]) begin
      wr(cfg_ix[i], 4'hA);
      rd(cfg_ix[i], 4'hA);
    end
    // port pins through the pad model
    wr(A_ROUTE1, 4'h0);
    wr(A_ROUTE2, 4'h0);
    wr(A_PORT_OE, 4'hF);
    wr(A_PORT_LOW, 4'hA);
    repeat (4) @(posedge clk);
    rd(A_PORT_LOW, 4'hA);
    wr(A_PORT_OE, 4'h0);
    repeat (4) @(posedge clk);
    rd(A_PORT_LOW, 4'h0);
    wr(A_PD_OFF, 4'hF);
    repeat (2) @(posedge clk);
    check("pull-down off", {28'h0, pd_off[3:0]}, 32'hF);
    wr(A_PD_OFF, 4'h0);
    wr(A_PORT_OE, 4'hF);
    wr(A_OPEN_DRAIN, 4'h1);
    wr(A_PORT_LOW, 4'hF);
    repeat (4) @(posedge clk);
    check("open drain enable", {31'h0, pa_oe[0]}, 32'h0);
    rd(A_PORT_LOW, 4'hE);
    wr(A_PORT_HIGH, 4'h6);
    repeat (4) @(posedge clk);
    rd(A_PORT_HIGH, 4'h6);
    wr(A_OPEN_DRAIN, 4'h0);
    wr(A_PORT_LOW, 4'h0);
    pwm <= 1'h1;
    wr(A_ROUTE1, 4'h1);
    repeat (2) @(posedge clk);
    check("pwm on pin 0", {31'h0, pa_o[0]}, 32'h1);
    // serial data both ways
    wr(A_SER_DATA_L, 4'h6);
    wr(A_SER_DATA_H, 4'h9);
    check("serial tx", {24'h0, ser_tx}, 32'h96);
    @(posedge clk);
    rx_d <= 8'h3C;
    rx_v <= 1'h1;
    @(posedge clk);
    rx_v <= 1'h0;
    rd(A_SER_DATA_L, 4'hC);
    rd(A_SER_DATA_H, 4'h3);
    ser_st <= 1'h1;
    wr(A_SER_CTRL2, 4'hB);
    rd(A_SER_CTRL2, 4'hF);
    // counter: reads see the running count, writes the load value
    cnt <= 10'h2A5;
    wr(A_CNT_HIGH, 4'hC);
    rd(A_CNT_LOW, 4'h5);
    rd(A_CNT_MID, 4'hA);
    rd(A_CNT_HIGH, 4'hE);
    wr(A_CNT_LOW, 4'h3);
    wr(A_CNT_MID, 4'h7);
    check("load value", {22'h0, cnt_lv}, 32'h073);
    check("bit select", {30'h0, cnt_bs}, 32'h3);
    wr(A_CNT_CTRL2, 4'hF);
    rd(A_CNT_CTRL2, 4'hE);
    check("counter control two", {29'h0, cnt_c2}, 32'h7);
    // interrupt flags
    pulse(8'h01);
    rd(A_FLAGS1, 4'h0);
    wr(A_MASK1, 4'hF);
    pulse(8'h05);
    rd(A_FLAGS1, 4'h5);
    rd(A_FLAGS1, 4'h0);
    pulse(8'h0A);
    wr(A_FLAGS1, 4'h2);
    rd(A_FLAGS1, 4'h8);
    pulse(8'hF0);
    rd(A_FLAGS2, 4'hA);
    pulse(8'h01);
    wr(A_SYS1, 4'hF);
    rd(A_SYS1, 4'hB);
    check("irq to cpu", {31'h0, irq_cpu}, 32'h1);
    wr(A_SYS1, 4'h0);
    halt <= 1'h1;
    repeat (4) @(posedge clk);
    rd(A_SYS1, 4'h8);
    halt <= 1'h0;
    wr(A_SYS2, 4'hC);
    rd(A_SYS2, 4'h5);
    check("sleep allow", {31'h0, sleep_allow}, 32'h1);
    // system reset only: power-on fields keep their values
    wr(A_SLEEP_CR, 4'h5);
    wr(A_SER_CTRL1, 4'h3);
    wr(A_EDGE_DEB, 4'h3);
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    rd(A_SLEEP_CR, 4'h5);
    rd(A_SER_CTRL1, 4'h0);
    rd(A_MASK1, 4'h0);
    rd(A_EDGE_DEB, 4'h3);
    rd(A_SYS2, 4'h5);
    print_verdict();
  end
endmodule // prm_periph_map_tb
